// *** core/eitc_config.sv ***
// Configuration bank of the video encoder: I2C slave, input format, video
// processing and timing-signal registers, with timing pin direction and polarity.
// Assumes gen_timing_in comes from the encoder's own timing generator on ref_clk_in
// as active-high levels, and that pins outside resolve open drain and tristate.
//
// Function
// - Three-bit input format field, blue screen 111.
// - Gamma select honoured only for linear RGB.
// - Overlay mixing field, resets to disabled.
// - Resolution bit selects half-resolution twofold upscale.
// - Luma lowpass enable bit, resets set.
// - Composite limiting bit clamps active video.
// - Subcarrier phase reset every 4/8 fields.
// - Pedestal bit adds blanking pedestal to RGB.
// - Pin assignment bit selects SCART mapping.
// - First active line parity, flicker only.
// - Flicker field: 00 off, 11 three-line.
// - Blank timing select bit, set drops the one-cycle first-pixel wait (blank output only).
// - Blank direction bit, resets to input.
// - Blank polarity bit.
// - Sync direction bit makes device timing master.
// - Line sync polarity bit.
// - Frame sync polarity bit.
// - Field polarity bit.
// - Reserved bits read zero, ignore writes.
// - I2C sub-addresses, pointer increments per byte.
`timescale 1ns/1ps

module eitc_config #(
   parameter int HAS_FLICKER = 1
) (
   input  wire logic                        ref_clk_in,
   input  wire logic                        rst_b_in,
   input  wire logic                        addr_sel_in,
   input  wire logic                        scl_in,
   input  wire logic                        sda_in,
   output logic                             sda_drive_out,
   output logic                             sda_oe_out,
   input  wire logic                        pal_mode_in,
   input  wire eitc_pkg::eitc_timing_type   gen_timing_in,
   input  wire eitc_pkg::eitc_timing_type   timing_pin_in,
   output eitc_pkg::eitc_timing_type        timing_pin_drive_out,
   output eitc_pkg::eitc_timing_type        timing_pin_oe_out,
   output eitc_pkg::eitc_timing_type        timing_out,
   output logic                             capture_active_out,
   output logic                             phase_reset_out,
   output eitc_pkg::eitc_video_cfg_type     cfg_out
);

   // ****************************************
   // Elaboration check
   // ****************************************
   if (HAS_FLICKER < 0 || HAS_FLICKER > 1) begin : g_bad_flicker
      $error("HAS_FLICKER must be 0 or 1.");
   end

   // Pin level from an active-high level, or back; the same mapping both ways.
   function automatic logic pin_map(input logic level, input logic pol);
      pin_map = ~(level ^ pol);
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic       scl_prev;
   logic       sda_prev;
   eitc_pkg::eitc_timing_type pin_meta;
   eitc_pkg::eitc_timing_type pin_sync;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
         pin_meta <= 4'h0;
         pin_sync <= 4'h0;
      end else begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         scl_prev <= scl_sync[1];
         sda_prev <= sda_sync[1];
         pin_meta <= timing_pin_in;
         pin_sync <= pin_meta;
      end
   end

   wire scl_s     = scl_sync[1];
   wire sda_s     = sda_sync[1];
   wire scl_rise  = scl_s & ~scl_prev;
   wire scl_fall  = ~scl_s & scl_prev;
   wire bus_start = scl_s & scl_prev & sda_prev & ~sda_s;
   wire bus_stop  = scl_s & scl_prev & ~sda_prev & sda_s;

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] input_format_config;
   logic [7:0] video_processing_config;
   logic [7:0] timing_signal_config;

   wire [1:0] flicker_field = (HAS_FLICKER == 1) ? video_processing_config[eitc_pkg::FLK_MSB:eitc_pkg::FLK_LSB]
                                                 : 2'h0;
   wire [7:0] video_read = {video_processing_config[7:2], flicker_field};

   // ****************************************
   // I2C slave
   // ****************************************
   eitc_pkg::eitc_i2c_state_type state;
   logic [7:0] shift;
   logic [7:0] tx;
   logic [3:0] bit_cnt;
   logic [6:0] pointer;
   logic       read_mode;
   logic       have_sub;
   logic       master_nack;

   wire [6:0] own_addr  = {eitc_pkg::I2C_BASE_ADDR[6:1], addr_sel_in};
   wire       byte_done = (bit_cnt == eitc_pkg::I2C_BYTE_BITS);
   wire       addr_hit  = (shift[7:1] == own_addr);
   wire       wr_strobe = scl_fall && (state == eitc_pkg::ST_WDATA) && byte_done;
   wire       sel_fmt   = (pointer == eitc_pkg::SUB_INPUT_FORMAT);
   wire       sel_video = (pointer == eitc_pkg::SUB_VIDEO_PROC);
   wire       sel_timing = (pointer == eitc_pkg::SUB_TIMING);
   wire [7:0] read_data = sel_fmt    ? (input_format_config & eitc_pkg::WMASK_INPUT_FORMAT) :
                          sel_video  ? video_read :
                          sel_timing ? (timing_signal_config & eitc_pkg::WMASK_TIMING) :
                                       8'h00;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         state       <= eitc_pkg::ST_IDLE;
         shift       <= 8'h00;
         tx          <= 8'h00;
         bit_cnt     <= 4'h0;
         pointer     <= 7'h00;
         read_mode   <= 1'b0;
         have_sub    <= 1'b0;
         master_nack <= 1'b0;
         sda_oe_out  <= 1'b0;
      end else if (bus_stop) begin
         state      <= eitc_pkg::ST_IDLE;
         sda_oe_out <= 1'b0;
      end else if (bus_start) begin
         state      <= eitc_pkg::ST_ADDR;
         bit_cnt    <= 4'h0;
         have_sub   <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
         shift   <= {shift[6:0], sda_s};
         if (state == eitc_pkg::ST_MACK) begin
            master_nack <= sda_s;
         end
         if (state != eitc_pkg::ST_IDLE && !byte_done) begin
            bit_cnt <= bit_cnt + 4'h1;
         end
      end else if (scl_fall) begin
         case (state)
            eitc_pkg::ST_ADDR: begin
               if (byte_done) begin
                  if (addr_hit) begin
                     read_mode  <= shift[0];
                     sda_oe_out <= 1'b1;
                     state      <= eitc_pkg::ST_ACK;
                  end else begin
                     state <= eitc_pkg::ST_IDLE;
                  end
               end
            end
            eitc_pkg::ST_SUB: begin
               if (byte_done) begin
                  pointer    <= shift[6:0];
                  have_sub   <= 1'b1;
                  sda_oe_out <= 1'b1;
                  state      <= eitc_pkg::ST_ACK;
               end
            end
            eitc_pkg::ST_WDATA: begin
               if (byte_done) begin
                  pointer    <= pointer + 7'h01;
                  sda_oe_out <= 1'b1;
                  state      <= eitc_pkg::ST_ACK;
               end
            end
            eitc_pkg::ST_ACK: begin
               bit_cnt <= 4'h0;
               if (read_mode) begin
                  tx         <= read_data;
                  pointer    <= pointer + 7'h01;
                  sda_oe_out <= ~read_data[7];
                  state      <= eitc_pkg::ST_RDATA;
               end else begin
                  sda_oe_out <= 1'b0;
                  state      <= have_sub ? eitc_pkg::ST_WDATA : eitc_pkg::ST_SUB;
               end
            end
            eitc_pkg::ST_RDATA: begin
               if (byte_done) begin
                  sda_oe_out <= 1'b0;
                  state      <= eitc_pkg::ST_MACK;
               end else begin
                  tx         <= {tx[6:0], 1'b0};
                  sda_oe_out <= ~tx[6];
               end
            end
            eitc_pkg::ST_MACK: begin
               bit_cnt <= 4'h0;
               if (master_nack) begin
                  state <= eitc_pkg::ST_IDLE;
               end else begin
                  tx         <= read_data;
                  pointer    <= pointer + 7'h01;
                  sda_oe_out <= ~read_data[7];
                  state      <= eitc_pkg::ST_RDATA;
               end
            end
            default: begin
               state <= eitc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Open drain: the line is only ever pulled low, never driven high.
   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         sda_drive_out <= 1'b0;
      end else begin
         sda_drive_out <= 1'b0;
      end
   end

   // ****************************************
   // Register writes
   // ****************************************
   wire [7:0] next_fmt_cfg    = shift & eitc_pkg::WMASK_INPUT_FORMAT;
   wire [7:0] next_timing_cfg = shift & eitc_pkg::WMASK_TIMING;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         input_format_config     <= eitc_pkg::RST_INPUT_FORMAT;
         video_processing_config <= eitc_pkg::RST_VIDEO_PROC;
         timing_signal_config    <= eitc_pkg::RST_TIMING;
      end else if (wr_strobe) begin
         if (sel_fmt) begin
            input_format_config <= next_fmt_cfg;
         end
         if (sel_video) begin
            video_processing_config <= shift & eitc_pkg::WMASK_VIDEO_PROC;
         end
         if (sel_timing) begin
            timing_signal_config <= next_timing_cfg;
         end
      end
   end

   // ****************************************
   // Video configuration decode
   // ****************************************
   wire [2:0] fmt        = input_format_config[eitc_pkg::FMT_MSB:eitc_pkg::FMT_LSB];
   wire       linear_rgb = (fmt == eitc_pkg::FMT_RGB16_LIN) || (fmt == eitc_pkg::FMT_RGB24_LIN);
   wire       flicker_en = (flicker_field == eitc_pkg::FLICKER_ON);
   eitc_pkg::eitc_video_cfg_type next_cfg;

   assign next_cfg.in_format       = fmt;
   assign next_cfg.blue_screen     = (fmt == eitc_pkg::FMT_BLUE);
   assign next_cfg.gamma_28        = linear_rgb & input_format_config[eitc_pkg::GAMMA_BIT];
   assign next_cfg.overlay_mix     = input_format_config[eitc_pkg::MIX_MSB:eitc_pkg::MIX_LSB];
   assign next_cfg.upscale_2x      = input_format_config[eitc_pkg::HALF_RES_BIT];
   assign next_cfg.luma_lowpass    = video_processing_config[eitc_pkg::LUMA_BIT];
   assign next_cfg.comp_limit      = video_processing_config[eitc_pkg::LIMIT_BIT];
   assign next_cfg.rgb_pedestal    = video_processing_config[eitc_pkg::PEDESTAL_BIT];
   assign next_cfg.scart_map       = video_processing_config[eitc_pkg::SCART_BIT];
   assign next_cfg.first_line_even = flicker_en & video_processing_config[eitc_pkg::FIRST_BIT];
   assign next_cfg.flicker_on      = flicker_en;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         cfg_out <= '0;
      end else begin
         cfg_out <= next_cfg;
      end
   end

   // ****************************************
   // Timing signal direction and polarity
   // ****************************************
   wire blank_master = timing_signal_config[eitc_pkg::BLK_DIR_BIT];
   wire sync_master  = timing_signal_config[eitc_pkg::SYNC_DIR_BIT];
   wire blank_pol    = timing_signal_config[eitc_pkg::BLK_POL_BIT];
   wire hs_pol       = timing_signal_config[eitc_pkg::HS_POL_BIT];
   wire vs_pol       = timing_signal_config[eitc_pkg::VS_POL_BIT];
   wire fld_pol      = timing_signal_config[eitc_pkg::FLD_POL_BIT];
   eitc_pkg::eitc_timing_type next_drive;
   eitc_pkg::eitc_timing_type next_oe;
   eitc_pkg::eitc_timing_type next_timing;

   assign next_drive.blank = pin_map(gen_timing_in.blank, blank_pol);
   assign next_drive.hsync = pin_map(gen_timing_in.hsync, hs_pol);
   assign next_drive.vsync = pin_map(gen_timing_in.vsync, vs_pol);
   assign next_drive.field = pin_map(gen_timing_in.field, fld_pol);
   assign next_oe.blank    = blank_master;
   assign next_oe.hsync    = sync_master;
   assign next_oe.vsync    = sync_master;
   assign next_oe.field    = sync_master;
   // Inputs are read through the same polarity mapping as outputs.
   assign next_timing.blank = blank_master ? gen_timing_in.blank : pin_map(pin_sync.blank, blank_pol);
   assign next_timing.hsync = sync_master ? gen_timing_in.hsync : pin_map(pin_sync.hsync, hs_pol);
   assign next_timing.vsync = sync_master ? gen_timing_in.vsync : pin_map(pin_sync.vsync, vs_pol);
   assign next_timing.field = sync_master ? gen_timing_in.field : pin_map(pin_sync.field, fld_pol);

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         timing_pin_drive_out <= 4'h0;
         timing_pin_oe_out    <= 4'h0;
         timing_out           <= 4'h0;
      end else begin
         timing_pin_drive_out <= next_drive;
         timing_pin_oe_out    <= next_oe;
         timing_out           <= next_timing;
      end
   end

   // ****************************************
   // First active pixel capture
   // ****************************************
   // The pin lags gen_timing_in by one register, so the one-cycle variant
   // waits for the registered level to have been inactive for a cycle.
   wire blank_tsel = blank_master & timing_signal_config[eitc_pkg::BLK_TSEL_BIT];
   wire next_capture = (blank_master && !blank_tsel) ? ~timing_out.blank & ~next_timing.blank
                                                     : ~next_timing.blank;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         capture_active_out <= 1'b0;
      end else begin
         capture_active_out <= next_capture;
      end
   end

   // ****************************************
   // Subcarrier phase reset
   // ****************************************
   logic [3:0] field_cnt;
   wire        field_edge  = next_timing.field ^ timing_out.field;
   wire [3:0]  field_limit = pal_mode_in ? eitc_pkg::PHASE_FIELDS_PAL : eitc_pkg::PHASE_FIELDS_NTSC;
   wire        phase_mode  = video_processing_config[eitc_pkg::PHASE_BIT];
   wire        phase_wrap  = (field_cnt >= field_limit - 4'h1);

   always_ff @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         field_cnt       <= 4'h0;
         phase_reset_out <= 1'b0;
      end else begin
         phase_reset_out <= phase_mode & field_edge & phase_wrap;
         if (field_edge) begin
            field_cnt <= phase_wrap ? 4'h0 : field_cnt + 4'h1;
         end
      end
   end

endmodule

// *** core/eitc_pkg.sv ***
// Constants, field layouts and carrier types of the encoder configuration bank.
// Assumes one clock domain; the I2C pins and timing pins arrive unsynchronised.
package eitc_pkg;

   // ****************************************
   // Bus addressing
   // ****************************************
   localparam logic [6:0] I2C_BASE_ADDR    = 7'h20;
   localparam logic [6:0] SUB_INPUT_FORMAT = 7'h02;
   localparam logic [6:0] SUB_VIDEO_PROC   = 7'h03;
   localparam logic [6:0] SUB_TIMING       = 7'h04;
   localparam logic [3:0] I2C_BYTE_BITS    = 4'h8;

   // ****************************************
   // Reset values and writable bits
   // ****************************************
   localparam logic [7:0] RST_INPUT_FORMAT  = 8'h06;
   localparam logic [7:0] RST_VIDEO_PROC    = 8'hA0;
   localparam logic [7:0] RST_TIMING        = 8'h00;
   localparam logic [7:0] WMASK_INPUT_FORMAT = 8'hF7;
   localparam logic [7:0] WMASK_VIDEO_PROC   = 8'hFF;
   localparam logic [7:0] WMASK_TIMING       = 8'hBF;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int FMT_MSB      = 7;
   localparam int FMT_LSB      = 5;
   localparam int GAMMA_BIT    = 4;
   localparam int MIX_MSB      = 2;
   localparam int MIX_LSB      = 1;
   localparam int HALF_RES_BIT = 0;
   localparam int LUMA_BIT     = 7;
   localparam int LIMIT_BIT    = 6;
   localparam int PHASE_BIT    = 5;
   localparam int PEDESTAL_BIT = 4;
   localparam int SCART_BIT    = 3;
   localparam int FIRST_BIT    = 2;
   localparam int FLK_MSB      = 1;
   localparam int FLK_LSB      = 0;
   localparam int BLK_TSEL_BIT = 7;
   localparam int BLK_DIR_BIT  = 5;
   localparam int BLK_POL_BIT  = 4;
   localparam int SYNC_DIR_BIT = 3;
   localparam int HS_POL_BIT   = 2;
   localparam int VS_POL_BIT   = 1;
   localparam int FLD_POL_BIT  = 0;

   // ****************************************
   // Codes and counts
   // ****************************************
   localparam logic [2:0] FMT_RGB16_LIN  = 3'h3;
   localparam logic [2:0] FMT_RGB24_LIN  = 3'h5;
   localparam logic [2:0] FMT_BLUE       = 3'h7;
   localparam logic [1:0] FLICKER_ON     = 2'h3;
   localparam logic [3:0] PHASE_FIELDS_NTSC = 4'h4;
   localparam logic [3:0] PHASE_FIELDS_PAL  = 4'h8;

   // ****************************************
   // Carrier types
   // ****************************************
   typedef struct packed {
      logic       blank;
      logic       hsync;
      logic       vsync;
      logic       field;
   } eitc_timing_type;

   typedef struct packed {
      logic [2:0] in_format;
      logic       blue_screen;
      logic       gamma_28;
      logic [1:0] overlay_mix;
      logic       upscale_2x;
      logic       luma_lowpass;
      logic       comp_limit;
      logic       rgb_pedestal;
      logic       scart_map;
      logic       first_line_even;
      logic       flicker_on;
   } eitc_video_cfg_type;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_SUB, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK
   } eitc_i2c_state_type;

endpackage

// *** test/eitc_config_properties.sv ***
// Port checker of the encoder configuration bank.
// Assumes the bind at the foot attaches it to every bank instance.
`timescale 1ns/1ps

module eitc_config_properties (
   input wire logic                         ref_clk_in,
   input wire logic                         rst_b_in,
   input wire eitc_pkg::eitc_timing_type    gen_timing_in,
   input wire eitc_pkg::eitc_timing_type    timing_pin_oe_out,
   input wire eitc_pkg::eitc_timing_type    timing_out,
   input wire logic                         capture_active_out,
   input wire logic                         phase_reset_out,
   input wire eitc_pkg::eitc_video_cfg_type cfg_out
);
   // ********
   // Checks
   // ********
   eitc_pkg::eitc_timing_type    oe;
   eitc_pkg::eitc_timing_type    tm;
   eitc_pkg::eitc_video_cfg_type cf;
   assign oe = timing_pin_oe_out;
   assign tm = timing_out;
   assign cf = cfg_out;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);

   reset_state_a: assert property ($rose(rst_b_in) |=> cf.overlay_mix == 2'h3 && cf.luma_lowpass
      && oe == 4'h0)
      else $error("state after reset differs");
   sync_pair_a: assert property (oe.hsync == oe.vsync && oe.vsync == oe.field)
      else $error("sync pin directions split");
   sync_master_a: assert property (oe.hsync && $past(oe.hsync) |->
      {tm.hsync, tm.vsync, tm.field} == $past({gen_timing_in.hsync, gen_timing_in.vsync, gen_timing_in.field}))
      else $error("master sync timing not from generator");
   blank_master_a: assert property (oe.blank && $past(oe.blank) |-> tm.blank == $past(gen_timing_in.blank))
      else $error("master blank not from generator");
   blue_code_a: assert property (cf.blue_screen == (cf.in_format == 3'h7))
      else $error("blue screen decode wrong");
   gamma_gate_a: assert property (cf.gamma_28 |-> cf.in_format == 3'h3 || cf.in_format == 3'h5)
      else $error("gamma active outside linear RGB");
   first_line_a: assert property (cf.first_line_even |-> cf.flicker_on)
      else $error("line parity active without flicker filter");
   phase_field_a: assert property (phase_reset_out |-> tm.field != $past(tm.field))
      else $error("phase reset without field change");
   cap_input_a: assert property ($fell(tm.blank) && !oe.blank |-> capture_active_out)
      else $error("capture late with blank as input");
   cap_output_a: assert property ($fell(tm.blank) && oe.blank |-> ##[0:1] capture_active_out)
      else $error("capture late with blank as output");
endmodule

bind eitc_config eitc_config_properties chk_u (
   .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .gen_timing_in(gen_timing_in),
   .timing_pin_oe_out(timing_pin_oe_out), .timing_out(timing_out),
   .capture_active_out(capture_active_out), .phase_reset_out(phase_reset_out), .cfg_out(cfg_out)
);

// *** test/eitc_i2c_host.sv ***
// I2C host model that reaches the bank's registers, stepped on the device clock.
// Assumes SDA is resolved outside with a pull-up; only this model drives SCL.
`timescale 1ns/1ps

module eitc_i2c_host #(
   parameter int QTR = 8
) (
   input  wire logic       clk_in,
   input  wire logic       sda_line_in,
   input  wire logic       addr_sel_in,
   output logic            scl_out,
   output logic            sda_out,
   output logic            rd_valid_out,
   output logic [7:0]      rd_data_out,
   output logic            nack_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
      rd_valid_out = 1'b0;
      rd_data_out = 8'h00;
      nack_out = 1'b0;
   end
   task automatic tq();
      repeat (QTR) @(posedge clk_in);
   endtask
   task automatic bit_x(input logic b, output logic r);
      sda_out <= b;
      tq();
      scl_out <= 1'b1;
      tq();
      r = sda_line_in;
      tq();
      scl_out <= 1'b0;
      tq();
   endtask
   task automatic byte_x(input logic [7:0] w, input logic ack, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
      bit_x(ack, a);
   endtask
   task automatic start_x();
      sda_out <= 1'b1;
      scl_out <= 1'b1;
      tq();
      sda_out <= 1'b0;
      tq();
      scl_out <= 1'b0;
      tq();
   endtask
   task automatic stop_x();
      sda_out <= 1'b0;
      tq();
      scl_out <= 1'b1;
      tq();
      sda_out <= 1'b1;
      tq();
   endtask
   // A set bad flag aims the transfer at the other slave address.
   task automatic head(input logic [6:0] sub, input logic bad);
      logic [7:0] r;
      logic       a;
      start_x();
      byte_x({eitc_pkg::I2C_BASE_ADDR | {6'h00, addr_sel_in ^ bad}, 1'b0}, 1'b1, r, a);
      nack_out <= a;
      byte_x({1'b0, sub}, 1'b1, r, a);
      nack_out <= nack_out | a;
   endtask
   task automatic write(input logic [6:0] sub, input logic [23:0] d, input int n, input logic bad);
      logic [7:0] r;
      logic       a;
      head(sub, bad);
      for (int k = 0; k < n; k++) begin
         byte_x(d[23 - 8 * k -: 8], 1'b1, r, a);
         nack_out <= nack_out | a;
      end
      stop_x();
   endtask
   task automatic read(input logic [6:0] sub, input int n);
      logic [7:0] r;
      logic       a;
      head(sub, 1'b0);
      start_x();
      byte_x({eitc_pkg::I2C_BASE_ADDR | {6'h00, addr_sel_in}, 1'b1}, 1'b1, r, a);
      nack_out <= nack_out | a;
      for (int k = 0; k < n; k++) begin
         byte_x(8'hFF, k == n - 1, r, a);
         rd_data_out <= r;
         rd_valid_out <= 1'b1;
         @(posedge clk_in);
         rd_valid_out <= 1'b0;
      end
      stop_x();
   endtask
endmodule

// *** test/test_encoder_input_timing_config.sv ***
// Self-checking bench of the encoder configuration bank.
// Assumes the host model and the checker are compiled before this file.
`timescale 1ns/1ps

module test_encoder_input_timing_config;
   logic                         ref_clk_in;
   logic                         rst_b_in;
   logic                         pal;
   logic                         scl, sda_h, sda_drv, sda_oe, rd_v, nack, cap, phs;
   logic [7:0]                   rd_d, a, v, t, exp_q [$];
   logic [3:0]                   pol, oe_e;
   eitc_pkg::eitc_timing_type    gen, ext, pin, drv, oe, tout;
   eitc_pkg::eitc_video_cfg_type cfg;
   int                           failures, num_checks, cyc, phs_n, n;
   wire                          sda_line = sda_oe ? sda_drv : sda_h;
   assign pin = (drv & oe) | (ext & ~oe);

   eitc_config dut_u (
      .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .addr_sel_in(1'b1), .scl_in(scl), .sda_in(sda_line),
      .sda_drive_out(sda_drv), .sda_oe_out(sda_oe), .pal_mode_in(pal), .gen_timing_in(gen),
      .timing_pin_in(pin), .timing_pin_drive_out(drv), .timing_pin_oe_out(oe), .timing_out(tout),
      .capture_active_out(cap), .phase_reset_out(phs), .cfg_out(cfg));
   eitc_i2c_host host_u (
      .clk_in(ref_clk_in), .sda_line_in(sda_line), .addr_sel_in(1'b1), .scl_out(scl), .sda_out(sda_h),
      .rd_valid_out(rd_v), .rd_data_out(rd_d), .nack_out(nack));

   // ********
   // Helpers
   // ********
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] ex);
      num_checks++;
      if (seen !== ex) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic wait_n(input int k);
      repeat (k) @(posedge ref_clk_in);
   endtask
   task automatic toggle(input int k);
      repeat (k) begin
         gen.field <= ~gen.field;
         wait_n(6);
      end
   endtask
   // The host keeps to legal format combinations only.
   task automatic legal(input logic [2:0] f);
      a[7:5] = f;
      if (f == 3'h5 || f == 3'h6) a[2:1] = 2'h3;
      if (f == 3'h2 && a[2:1] == 2'h1) a[2:1] = 2'h0;
      if (f == 3'h2 || v[1:0] != 2'h0) a[0] = 1'b0;
      if (f == 3'h1 || f == 3'h2 || a[0]) v[1:0] = 2'h0;
   endtask
   function automatic eitc_pkg::eitc_video_cfg_type decode(input logic [7:0] fa, input logic [7:0] fv);
      return {fa[7:5], fa[7:5] == 3'h7, fa[4] & (fa[7:5] == 3'h3 || fa[7:5] == 3'h5), fa[2:1], fa[0],
              fv[7], fv[6], fv[4], fv[3], fv[2] & (fv[1:0] == 2'h3), fv[1:0] == 2'h3};
   endfunction

   initial begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 60000) begin
         failures++;
         report_and_stop();
      end
      if (rd_v === 1'b1) check("read", 16'(rd_d), exp_q.size() ? 16'(exp_q.pop_front()) : 16'hXXXX);
      if (phs === 1'b1) phs_n++;
   end

   // ********
   // Scenarios
   // ********
   initial begin
      rst_b_in = 1'b0;
      pal = 1'b0;
      gen = 4'h0;
      ext = 4'h0;
      void'($urandom(70));
      wait_n(20);
      rst_b_in <= 1'b1;
      wait_n(4);
      check("cfg reset", 16'(cfg), 16'(decode(8'h06, 8'hA0)));
      check("oe reset", 16'(oe), 16'h0);
      host_u.write(7'h02, 24'hE10000, 1, 1'b1);
      check("foreign address", 16'(nack), 16'h1);
      exp_q = '{8'h06, 8'hA0, 8'h00, 8'h00};
      host_u.read(7'h02, 4);
      for (int i = 0; i < 8; i++) begin
         a = 8'($urandom());
         v = 8'($urandom());
         if (i[0]) v[1:0] = 2'h3;
         legal(i[2:0]);
         host_u.write(7'h02, {a, v, 8'h00}, 2, 1'b0);
         check("ack", 16'(nack), 16'h0);
         exp_q.push_back(a & 8'hF7);
         exp_q.push_back(v);
         host_u.read(7'h02, 2);
         check("cfg", 16'(cfg), 16'(decode(a, v)));
      end
      for (int i = 0; i < 4; i++) begin
         t = 8'($urandom());
         t[5] = i[0];
         t[3] = i[1];
         host_u.write(7'h04, {t, 16'h0000}, 1, 1'b0);
         exp_q.push_back(t & 8'hBF);
         host_u.read(7'h04, 1);
         pol = {t[4], t[2], t[1], t[0]};
         oe_e = {t[5], {3{t[3]}}};
         for (int k = 0; k < 3; k++) begin
            gen <= 4'($urandom());
            ext <= 4'($urandom());
            wait_n(5);
            check("oe", 16'(oe), 16'(oe_e));
            check("drive", 16'(drv), 16'(4'(~(gen ^ pol))));
            check("timing", 16'(tout), 16'(4'((gen & oe_e) | (~(ext ^ pol) & ~oe_e))));
         end
      end
      for (int j = 0; j < 2; j++) begin
         host_u.write(7'h04, {j[0], 7'h28, 16'h0000}, 1, 1'b0);
         gen <= 4'h8;
         wait_n(4);
         check("blanked", 16'(cap), 16'h0);
         gen <= 4'h0;
         for (n = 1; n < 8; n++) begin
            @(posedge ref_clk_in);
            #1;
            if (cap === 1'b1) break;
         end
         check("first pixel", 16'(n), j ? 16'h1 : 16'h2);
      end
      host_u.write(7'h03, 24'hA00000, 1, 1'b0);
      for (int p = 0; p < 3; p++) begin
         pal <= (p == 1);
         if (p == 2) host_u.write(7'h03, 24'h800000, 1, 1'b0);
         toggle(8);
         phs_n = 0;
         toggle(16);
         check("phase resets", 16'(phs_n), p == 0 ? 16'h4 : (p == 1 ? 16'h2 : 16'h0));
      end
      check("pending", 16'(exp_q.size()), 16'h0);
      report_and_stop();
   end
endmodule
